/* File: logic/crt_timer.sv */
// Sixteen-bit capture/reload timer with register port, pin sampling and serial clock routing.
//
// Notes on behaviour
// - Sixteen-bit counter, high and low byte.
// - Timer function counts once per twelve clocks.
// - Source select picks timer or pin edges.
// - Count pin sampled once per cycle, high-then-low counts.
// - Edge count visible at next update phase.
// - Pin count rate limited to clock/24.
// - Run bit clear stops count, flag setting and trigger; other-timer clock routing continues.
// - Mode decoded from clock selects and capture select.
// - Capture select picks capture or reload behaviour.
// - Serial clock selects force reload on overflow.
// - Overflow flag set on overflow, never in baud.
// - Edge flag set by trigger capture or reload.
// - Flags request interrupt, edge flag not in up/down.
// - Receive clock select routes overflow pulses.
// - Transmit clock select routes overflow pulses.
// - Trigger enable lets trigger edges act.
// - Capture mode counts freely, overflow sets flag.
// - Trigger edge copies count into capture pair.
// - Up-count overflow reloads from the pair.
// - Down enable lets trigger level set direction.
// - Down count underflow at pair, loads all-ones.
// - Baud mode counts every state time.
//
// Design decision made here: the strobed register port.
`timescale 1ns/10ps
`include "crt_defs.svh"

module crt_timer #(
	parameter int PHASES = `CRT_PHASES
)(
	input  wire logic        clk_sys,
	input  wire logic        arst_n,
	input  wire logic [7:0]  reg_addr,
	input  wire logic [7:0]  reg_wdata,
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	output logic      [7:0]  reg_rdata,
	input  wire logic        count_input_pin,
	input  wire logic        trigger_input_pin,
	input  wire logic        t1_ovf_pulse,
	output logic             rx_clk_pulse,
	output logic             tx_clk_pulse,
	output logic             irq_req
);

	////////////////////////////////////////////////////////////////////////////////////////////////

	function automatic logic [15:0] crt_step(input logic [15:0] val, input logic dn);
		crt_step = dn ? 16'(val - `CRT_CNT_ONE) : 16'(val + `CRT_CNT_ONE);
	endfunction

	logic [3:0]          phase_ff;
	logic [7:0]          ctl_ff;
	logic [1:0]          mod_ff;
	logic [15:0]         cnt_ff;
	logic [15:0]         cap_ff;
	logic                cin_ff;
	logic                cedge_ff;
	logic                tin_ff;
	logic                tedge_ff;
	logic [7:0]          reg_rdata_ff;
	logic                rx_clk_pulse_ff;
	logic                tx_clk_pulse_ff;
	logic                irq_req_ff;

	logic [3:0]          nxt_phase;
	logic [15:0]         nxt_cnt;
	logic [15:0]         nxt_cap;
	logic [7:0]          nxt_ctl;
	crt_pkg::crt_mode_t  mode;

	////////////////////////////////////////////////////////////////////////////////////////////////
	// Register port decode.

	wire wr_ctl    = reg_wr && reg_addr == `CRT_OFF_CONTROL;
	wire wr_mod    = reg_wr && reg_addr == `CRT_OFF_MODE;
	wire wr_cap_lo = reg_wr && reg_addr == `CRT_OFF_CAP_LO;
	wire wr_cap_hi = reg_wr && reg_addr == `CRT_OFF_CAP_HI;
	wire wr_cnt_lo = reg_wr && reg_addr == `CRT_OFF_CNT_LO;
	wire wr_cnt_hi = reg_wr && reg_addr == `CRT_OFF_CNT_HI;
	wire cnt_wr    = wr_cnt_lo || wr_cnt_hi;
	wire cap_wr    = wr_cap_lo || wr_cap_hi;

	wire [7:0] rd_mux =
		(reg_addr == `CRT_OFF_CONTROL) ? ctl_ff :
		(reg_addr == `CRT_OFF_MODE)    ? {6'h00, mod_ff} :
		(reg_addr == `CRT_OFF_CAP_LO)  ? cap_ff[7:0] :
		(reg_addr == `CRT_OFF_CAP_HI)  ? cap_ff[15:8] :
		(reg_addr == `CRT_OFF_CNT_LO)  ? cnt_ff[7:0] :
		(reg_addr == `CRT_OFF_CNT_HI)  ? cnt_ff[15:8] : `CRT_BYTE_ZERO;

	////////////////////////////////////////////////////////////////////////////////////////////////
	// Control field decode and mode selection.

	wire tf_bit   = ctl_ff[`CRT_CTL_TF];
	wire exf_bit  = ctl_ff[`CRT_CTL_EXF];
	wire rclk     = ctl_ff[`CRT_CTL_RCLK];
	wire tx_clock_select     = ctl_ff[`CRT_CTL_TX_CLOCK_SELECT];
	wire exen     = ctl_ff[`CRT_CTL_EXEN];
	wire run      = ctl_ff[`CRT_CTL_RUN];
	wire cst      = ctl_ff[`CRT_CTL_CST];
	wire cprl     = ctl_ff[`CRT_CTL_CPRL];
	wire down_count_enable     = mod_ff[`CRT_MOD_DOWN_COUNT_ENABLE];
	wire baud_sel = rclk || tx_clock_select;

	assign mode = !run     ? crt_pkg::CRT_MODE_OFF :
	              baud_sel ? crt_pkg::CRT_MODE_BAUD :
	              cprl     ? crt_pkg::CRT_MODE_CAPTURE : crt_pkg::CRT_MODE_RELOAD;

	wire m_reload  = mode == crt_pkg::CRT_MODE_RELOAD;
	wire m_capture = mode == crt_pkg::CRT_MODE_CAPTURE;
	wire m_baud    = mode == crt_pkg::CRT_MODE_BAUD;

	////////////////////////////////////////////////////////////////////////////////////////////////
	// Machine cycle phases; one machine cycle is PHASES clocks, one state time is two.

	wire ph_last    = phase_ff == 4'(PHASES - 1);
	wire sample_now = phase_ff == `CRT_SAMPLE_PH;
	wire update_now = phase_ff == `CRT_UPDATE_PH;
	wire state_tick = phase_ff[0];

	assign nxt_phase = ph_last ? `CRT_PH_ZERO : 4'(phase_ff + `CRT_PH_ONE);

	////////////////////////////////////////////////////////////////////////////////////////////////
	// Count events. Pin edges take two machine cycles to see, which caps the pin rate at clock/24.

	wire up_down   = m_reload && down_count_enable;
	wire count_dn  = up_down && !tin_ff;
	wire pin_tick  = update_now && cedge_ff;
	wire tmr_tick  = m_baud ? state_tick : update_now;
	wire cnt_tick  = run && (cst ? pin_tick : tmr_tick);
	wire at_top    = cnt_ff == `CRT_CNT_TOP;
	wire at_cap    = cnt_ff == cap_ff;
	wire roll      = cnt_tick && (count_dn ? at_cap : at_top);
	wire trig_evt  = run && exen && update_now && tedge_ff && !up_down;
	wire baud_roll = roll && m_baud;

	always_comb
	begin
		nxt_cnt = cnt_ff;
		nxt_cap = cap_ff;
		case (mode)
			crt_pkg::CRT_MODE_RELOAD:
			begin
				if (trig_evt)
					nxt_cnt = cap_ff;
				else if (roll)
					nxt_cnt = count_dn ? `CRT_CNT_TOP : cap_ff;
				else if (cnt_tick)
					nxt_cnt = crt_step(cnt_ff, count_dn);
			end
			crt_pkg::CRT_MODE_CAPTURE:
			begin
				if (cnt_tick)
					nxt_cnt = crt_step(cnt_ff, 1'b0);
				if (trig_evt)
					nxt_cap = cnt_ff;
			end
			crt_pkg::CRT_MODE_BAUD:
			begin
				if (roll)
					nxt_cnt = cap_ff;
				else if (cnt_tick)
					nxt_cnt = crt_step(cnt_ff, 1'b0);
			end
			crt_pkg::CRT_MODE_OFF:
			begin
				nxt_cnt = cnt_ff;
			end
			default:
			begin
				nxt_cnt = cnt_ff;
			end
		endcase
		// Software writes win over the count; stop the timer before touching the count.
		if (wr_cnt_lo)
			nxt_cnt[7:0] = reg_wdata;
		if (wr_cnt_hi)
			nxt_cnt[15:8] = reg_wdata;
		if (wr_cap_lo)
			nxt_cap[7:0] = reg_wdata;
		if (wr_cap_hi)
			nxt_cap[15:8] = reg_wdata;
	end

	////////////////////////////////////////////////////////////////////////////////////////////////
	// Control register with hardware flags; a hardware set wins over a software clear.

	wire tf_set   = roll && !m_baud;
	wire exf_set  = trig_evt;
	wire exf_tog  = roll && up_down;
	wire [7:0] ctl_base = wr_ctl ? reg_wdata : ctl_ff;

	always_comb
	begin
		nxt_ctl = ctl_base;
		nxt_ctl[`CRT_CTL_TF] = ctl_base[`CRT_CTL_TF] || tf_set;
		nxt_ctl[`CRT_CTL_EXF] = exf_tog ? !ctl_base[`CRT_CTL_EXF] : (ctl_base[`CRT_CTL_EXF] || exf_set);
	end

	////////////////////////////////////////////////////////////////////////////////////////////////
	// Registers.

	always_ff @(posedge clk_sys or negedge arst_n)
	begin
		if (!arst_n)
		begin
			phase_ff <= `CRT_PH_ZERO;
			ctl_ff   <= `CRT_CTL_RESET;
			mod_ff   <= `CRT_MOD_RESET;
			cnt_ff   <= `CRT_CNT_ZERO;
			cap_ff   <= `CRT_CNT_ZERO;
		end
		else
		begin
			phase_ff <= nxt_phase;
			ctl_ff   <= nxt_ctl;
			mod_ff   <= wr_mod ? reg_wdata[1:0] : mod_ff;
			cnt_ff   <= nxt_cnt;
			cap_ff   <= nxt_cap;
		end
	end

	// Pin sampling once per machine cycle; an edge waits in a pending bit until the update phase.
	// Samplers reset to the idle high level, so no false edge follows reset and the direction starts as up.
	always_ff @(posedge clk_sys or negedge arst_n)
	begin
		if (!arst_n)
		begin
			cin_ff   <= 1'b1;
			cedge_ff <= 1'b0;
			tin_ff   <= 1'b1;
			tedge_ff <= 1'b0;
		end
		else if (sample_now)
		begin
			cin_ff   <= count_input_pin;
			cedge_ff <= cin_ff && !count_input_pin;
			tin_ff   <= trigger_input_pin;
			tedge_ff <= tin_ff && !trigger_input_pin;
		end
		else if (update_now)
		begin
			cedge_ff <= 1'b0;
			tedge_ff <= 1'b0;
		end
	end

	always_ff @(posedge clk_sys or negedge arst_n)
	begin
		if (!arst_n)
		begin
			reg_rdata_ff    <= `CRT_BYTE_ZERO;
			rx_clk_pulse_ff <= 1'b0;
			tx_clk_pulse_ff <= 1'b0;
			irq_req_ff      <= 1'b0;
		end
		else
		begin
			reg_rdata_ff    <= reg_rd ? rd_mux : `CRT_BYTE_ZERO;
			rx_clk_pulse_ff <= rclk ? baud_roll : t1_ovf_pulse;
			tx_clk_pulse_ff <= tx_clock_select ? baud_roll : t1_ovf_pulse;
			irq_req_ff      <= tf_bit || (exf_bit && !down_count_enable);
		end
	end

	assign reg_rdata    = reg_rdata_ff;
	assign rx_clk_pulse = rx_clk_pulse_ff;
	assign tx_clk_pulse = tx_clk_pulse_ff;
	assign irq_req      = irq_req_ff;

	////////////////////////////////////////////////////////////////////////////////////////////////
	// Checks.

	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (!arst_n);

	phase_wrap_a: assert property (ph_last |=> phase_ff == `CRT_PH_ZERO ##4 update_now)
		else $error("phase counter did not wrap");
	timer_inc_a: assert property (m_reload && !cst && !down_count_enable && update_now && !trig_evt && !at_top && !cnt_wr
		|=> cnt_ff == 16'($past(cnt_ff) + `CRT_CNT_ONE))
		else $error("timer did not increment once per machine cycle");
	off_hold_a: assert property (!run && !cnt_wr |=> $stable(cnt_ff))
		else $error("count moved while stopped");
	edge_seen_a: assert property (sample_now && cin_ff && !count_input_pin |=> cedge_ff)
		else $error("count pin edge not caught");
	update_phase_a: assert property (!m_baud && !cnt_wr && nxt_cnt != cnt_ff |-> update_now)
		else $error("count changed outside update phase");
	tf_set_a: assert property (roll && !m_baud |=> tf_bit)
		else $error("overflow flag not set");
	tf_baud_a: assert property (m_baud && !tf_bit && !wr_ctl |=> !tf_bit)
		else $error("overflow flag set in baud mode");
	capture_copy_a: assert property (m_capture && trig_evt && !cap_wr |=> cap_ff == $past(cnt_ff) && exf_bit)
		else $error("capture did not copy count");
	reload_ovf_a: assert property (m_reload && !down_count_enable && roll && !trig_evt && !cnt_wr
		|=> cnt_ff == $past(cap_ff))
		else $error("overflow did not reload");
	down_under_a: assert property (count_dn && roll && !cnt_wr |=> cnt_ff == `CRT_CNT_TOP)
		else $error("underflow did not load all ones");
	baud_rate_a: assert property (m_baud && !cst && state_tick && !roll && !cnt_wr ##1 m_baud && !cnt_wr
		|=> cnt_ff == 16'($past(cnt_ff, 2) + `CRT_CNT_ONE))
		else $error("baud mode did not count every state time");
	irq_updown_a: assert property (down_count_enable && !tf_bit |=> !irq_req)
		else $error("interrupt raised in up/down mode");
	route_rx_a: assert property (rclk && baud_roll |=> rx_clk_pulse)
		else $error("receive clock pulse missing");

	// Phase, pin, trigger and direction checks.
	phase_range_a: assert property (phase_ff <= 4'(PHASES - 1))
		else $error("phase counter out of range");
	sample_only_a: assert property (!sample_now |=> $stable(cin_ff))
		else $error("count pin sampled outside sample phase");
	pend_hold_a: assert property (cedge_ff && !update_now |=> cedge_ff)
		else $error("pending count edge lost before update phase");
	pin_once_a: assert property (pin_tick |=> !cedge_ff)
		else $error("pending count edge used twice");
	pin_step_a: assert property (m_capture && cst && pin_tick && !at_top && !cnt_wr
		|=> cnt_ff == 16'($past(cnt_ff) + `CRT_CNT_ONE))
		else $error("pin edge did not advance the count");
	pin_quiet_a: assert property (run && cst && !pin_tick && !trig_evt && !cnt_wr |=> $stable(cnt_ff))
		else $error("count moved without a pin edge");
	trig_off_a: assert property (!exen && !up_down && !exf_bit && !wr_ctl |=> !exf_bit)
		else $error("edge flag set with trigger disabled");
	trig_reload_a: assert property (m_reload && trig_evt && !cnt_wr
		|=> cnt_ff == $past(cap_ff) && exf_bit)
		else $error("trigger edge did not reload");
	baud_trig_a: assert property (m_baud && !cst && trig_evt && !cnt_wr
		|=> $stable(cnt_ff) && exf_bit)
		else $error("trigger edge reloaded a baud generator");
	down_step_a: assert property (count_dn && cnt_tick && !roll && !cnt_wr
		|=> cnt_ff == 16'($past(cnt_ff) - `CRT_CNT_ONE))
		else $error("down count did not decrement");
	up_step_a: assert property (up_down && tin_ff && cnt_tick && !roll && !cnt_wr
		|=> cnt_ff == 16'($past(cnt_ff) + `CRT_CNT_ONE))
		else $error("up count did not increment");
	mode_write_a: assert property (wr_mod |=> mod_ff == $past(reg_wdata[1:0]))
		else $error("mode register write lost");

	// Flag, count, capture pair, routing and read port checks.
	tf_hold_a: assert property (tf_bit && !wr_ctl |=> tf_bit)
		else $error("overflow flag cleared by hardware");
	off_flags_a: assert property (!run && !tf_bit && !wr_ctl |=> !tf_bit)
		else $error("overflow flag set while stopped");
	exf_hold_a: assert property (exf_bit && !wr_ctl && !up_down |=> exf_bit)
		else $error("edge flag cleared by hardware");
	capture_wrap_a: assert property (m_capture && roll && !cnt_wr |=> cnt_ff == `CRT_CNT_ZERO && tf_bit)
		else $error("capture mode overflow did not wrap and flag");
	cap_hold_a: assert property (!cap_wr && !(m_capture && trig_evt) |=> $stable(cap_ff))
		else $error("capture pair changed without a capture");
	baud_reload_a: assert property (m_baud && roll && !cnt_wr |=> cnt_ff == $past(cap_ff))
		else $error("baud rollover did not reload");
	irq_flag_a: assert property (tf_bit |=> irq_req)
		else $error("overflow flag raised no request");
	route_tx_a: assert property (tx_clock_select && baud_roll |=> tx_clk_pulse)
		else $error("transmit clock pulse missing");
	rx_quiet_a: assert property (rclk && !baud_roll |=> !rx_clk_pulse)
		else $error("receive clock pulse without rollover");
	rx_t1_a: assert property (!rclk |=> rx_clk_pulse == $past(t1_ovf_pulse))
		else $error("receive clock not taken from other timer");
	tx_t1_a: assert property (!tx_clock_select |=> tx_clk_pulse == $past(t1_ovf_pulse))
		else $error("transmit clock not taken from other timer");
	rdata_idle_a: assert property (!reg_rd |=> reg_rdata == `CRT_BYTE_ZERO)
		else $error("read data not cleared after read");
	rdata_high_a: assert property (reg_rd && reg_addr == `CRT_OFF_CNT_HI
		|=> reg_rdata == $past(cnt_ff[15:8]))
		else $error("count high byte read wrong");

	capture_seen_c: cover property (m_capture && trig_evt);
	down_roll_c: cover property (count_dn && roll);
	baud_roll_c: cover property (baud_roll ##1 tx_clk_pulse);
	trig_reload_c: cover property (m_reload && trig_evt);
	pin_count_c: cover property (cst && pin_tick);

endmodule

/* File: logic/crt_defs.svh */
// Register offsets, field positions, reset values and phase constants of the capture/reload timer.
`ifndef CRT_DEFS_SVH
`define CRT_DEFS_SVH

`define CRT_OFF_CONTROL     8'hC8
`define CRT_OFF_MODE        8'hC9
`define CRT_OFF_CAP_LO      8'hCA
`define CRT_OFF_CAP_HI      8'hCB
`define CRT_OFF_CNT_LO      8'hCC
`define CRT_OFF_CNT_HI      8'hCD

`define CRT_CTL_TF          7
`define CRT_CTL_EXF         6
`define CRT_CTL_RCLK        5
`define CRT_CTL_TX_CLOCK_SELECT        4
`define CRT_CTL_EXEN        3
`define CRT_CTL_RUN         2
`define CRT_CTL_CST         1
`define CRT_CTL_CPRL        0
`define CRT_MOD_CLKOUT      1
`define CRT_MOD_DOWN_COUNT_ENABLE        0

`define CRT_CTL_RESET       8'h00
`define CRT_MOD_RESET       2'h0
`define CRT_BYTE_ZERO       8'h00
`define CRT_CNT_ZERO        16'h0000
`define CRT_CNT_TOP         16'hFFFF
`define CRT_CNT_ONE         16'h0001

`define CRT_PHASES          12
`define CRT_PH_ZERO         4'h0
`define CRT_PH_ONE          4'h1
`define CRT_SAMPLE_PH       4'h9
`define CRT_UPDATE_PH       4'h4

`endif

/* File: logic/crt_pkg.sv */
// Types shared by the capture/reload timer.
package crt_pkg;

	typedef enum logic [3:0]
	{
		CRT_MODE_OFF     = 4'h1,
		CRT_MODE_RELOAD  = 4'h2,
		CRT_MODE_CAPTURE = 4'h4,
		CRT_MODE_BAUD    = 4'h8
	} crt_mode_t;

endpackage

/* File: test/crt_pin_source.sv */
// Model of the external count and trigger sources that drive the timer pins.
`timescale 1ns/10ps

module crt_pin_source (
	input  wire logic clk_sys,
	output logic      count_input_pin,
	output logic      trigger_input_pin
);
	// Both pins idle high, as the port pull-ups would hold them.
	initial
	begin
		count_input_pin   = 1'b1;
		trigger_input_pin = 1'b1;
	end

	task automatic hold(input int n);
		repeat (n) @(posedge clk_sys);
	endtask

	// Each level lasts one full machine cycle so that it is sampled exactly once.
	task automatic count_edges(input int n);
		repeat (n)
		begin
			count_input_pin <= 1'b0;
			hold(12);
			count_input_pin <= 1'b1;
			hold(12);
		end
	endtask

	task automatic trig_fall();
		trigger_input_pin <= 1'b0;
		hold(12);
		trigger_input_pin <= 1'b1;
		hold(24);
	endtask

	task automatic set_trig(input logic lvl);
		trigger_input_pin <= lvl;
		hold(24);
	endtask
endmodule

/* File: test/crt_timer_tb_top.sv */
// Self-checking testbench of the capture/reload timer.
`timescale 1ns/10ps
`include "crt_defs.svh"

module crt_timer_tb_top;
	localparam logic [7:0] CTL = `CRT_OFF_CONTROL;
	localparam logic [7:0] MD  = `CRT_OFF_MODE;
	localparam logic [7:0] CAP = `CRT_OFF_CAP_LO;
	localparam logic [7:0] CNT = `CRT_OFF_CNT_LO;
	logic       clk_sys;
	logic       arst_n;
	logic [7:0] reg_addr;
	logic [7:0] reg_wdata;
	logic       reg_wr;
	logic       reg_rd;
	logic [7:0] reg_rdata;
	logic       count_input_pin;
	logic       trigger_input_pin;
	logic       t1_ovf_pulse;
	logic       rx_clk_pulse;
	logic       tx_clk_pulse;
	logic       irq_req;
	logic [7:0] rdv;
	int         n_fail = 0;
	int         checks = 0;
	int         n_rx = 0;
	int         n_tx = 0;
	int         n_irq = 0;
	int         b_rx;
	int         b_tx;
	int         b_irq;

	crt_timer i_crt_timer (.clk_sys(clk_sys), .arst_n(arst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .count_input_pin(count_input_pin),
		.trigger_input_pin(trigger_input_pin), .t1_ovf_pulse(t1_ovf_pulse), .rx_clk_pulse(rx_clk_pulse),
		.tx_clk_pulse(tx_clk_pulse), .irq_req(irq_req));
	crt_pin_source i_crt_pin_source (.clk_sys(clk_sys), .count_input_pin(count_input_pin),
		.trigger_input_pin(trigger_input_pin));

	always #4 clk_sys = ~clk_sys;

	always @(posedge clk_sys)
	begin
		if (rx_clk_pulse === 1'b1) n_rx <= n_rx + 1;
		if (tx_clk_pulse === 1'b1) n_tx <= n_tx + 1;
		if (irq_req === 1'b1) n_irq <= n_irq + 1;
	end

	////////////////////////////////////////////////////////////
	task automatic tick(input int n);
		repeat (n) @(posedge clk_sys);
	endtask

	// One idle cycle follows every access so a strobe is never set twice in one step.
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		reg_addr  <= a;
		reg_wdata <= d;
		reg_wr    <= 1'b1;
		@(posedge clk_sys);
		reg_wr <= 1'b0;
		@(posedge clk_sys);
	endtask

	task automatic wr16(input logic [7:0] a, input logic [15:0] d);
		wr(a, d[7:0]);
		wr(8'(a + 8'h01), d[15:8]);
	endtask

	task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
		checks++;
		if (g !== e)
		begin
			n_fail++;
			$display("Error %s expected %h seen %h", nm, e, g);
		end
	endtask

	task automatic rchk(input string nm, input logic [7:0] a, input logic [7:0] e);
		reg_addr <= a;
		reg_rd   <= 1'b1;
		@(posedge clk_sys);
		reg_rd <= 1'b0;
		#1;
		rdv = reg_rdata;
		@(posedge clk_sys);
		chk(nm, e, rdv);
	endtask

	task automatic rchk16(input string nm, input logic [7:0] a, input logic [15:0] e);
		rchk(nm, a, e[7:0]);
		rchk(nm, 8'(a + 8'h01), e[15:8]);
	endtask

	// Sample the registered request away from the edge that updates it.
	task automatic irq_chk(input string nm, input logic e);
		#1;
		chk(nm, {7'h00, e}, {7'h00, irq_req});
		@(posedge clk_sys);
	endtask

	// Run for exactly k machine cycles, counted from the write that starts it.
	task automatic run_for(input logic [7:0] on, input int k);
		wr(CTL, on);
		tick(12 * k - 2);
		wr(CTL, 8'h00);
	endtask

	task automatic end_of_test();
		$display("checks %0d mismatches %0d", checks, n_fail);
		if (n_fail == 0 && checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	////////////////////////////////////////////////////////////
	// The whole sequence needs about 770 clocks; the limit leaves ample margin.
	initial
	begin
		#50000;
		n_fail++;
		$display("Error watchdog expected finish seen timeout");
		end_of_test();
	end

	initial
	begin
		clk_sys      = 1'b0;
		arst_n       = 1'b0;
		reg_addr     = 8'h00;
		reg_wdata    = 8'h00;
		reg_wr       = 1'b0;
		reg_rd       = 1'b0;
		t1_ovf_pulse = 1'b0;
		tick(6);
		arst_n <= 1'b1;
		tick(1);
		for (int a = 8'hc8; a <= 8'hcd; a++) rchk("reset value", 8'(a), 8'h00);
		wr(MD, 8'hff);
		rchk("mode bits", MD, 8'h03);
		wr(MD, 8'h00);
		wr(8'hce, 8'hff);
		rchk("unmapped", 8'hce, 8'h00);
		wr16(CAP, 16'ha55a);
		rchk16("capture pair", CAP, 16'ha55a);
		$display("register test done");
		wr16(CNT, 16'h0000);
		run_for(8'h04, 5);
		rchk16("timer count", CNT, 16'h0005);
		tick(24);
		rchk16("stopped count", CNT, 16'h0005);
		wr(CTL, 8'h06);
		i_crt_pin_source.count_edges(3);
		tick(24);
		wr(CTL, 8'h00);
		rchk16("pin count", CNT, 16'h0008);
		$display("count test done");
		wr16(CAP, 16'h1234);
		wr16(CNT, 16'hffff);
		wr(CTL, 8'h06);
		i_crt_pin_source.count_edges(1);
		tick(24);
		rchk("overflow flag", CTL, 8'h86);
		rchk16("reload value", CNT, 16'h1234);
		irq_chk("irq overflow", 1'b1);
		wr(CTL, 8'h00);
		tick(2);
		irq_chk("irq cleared", 1'b0);
		wr16(CNT, 16'hffff);
		wr(CTL, 8'h07);
		i_crt_pin_source.count_edges(1);
		tick(24);
		rchk("capture overflow", CTL, 8'h87);
		rchk16("capture wrap", CNT, 16'h0000);
		wr16(CNT, 16'h0100);
		wr(CTL, 8'h07);
		i_crt_pin_source.trig_fall();
		rchk("trigger ignored", CTL, 8'h07);
		wr(CTL, 8'h0f);
		i_crt_pin_source.trig_fall();
		rchk("edge flag", CTL, 8'h4f);
		rchk16("captured pair", CAP, 16'h0100);
		irq_chk("irq edge", 1'b1);
		wr16(CAP, 16'habcd);
		wr16(CNT, 16'h0050);
		wr(CTL, 8'h0e);
		i_crt_pin_source.trig_fall();
		wr(CTL, 8'h00);
		rchk16("trigger reload", CNT, 16'habcd);
		$display("capture test done");
		wr16(CAP, 16'h0010);
		wr16(CNT, 16'h0011);
		wr(MD, 8'h01);
		i_crt_pin_source.set_trig(1'b0);
		wr(CTL, 8'h06);
		i_crt_pin_source.count_edges(3);
		tick(24);
		rchk("underflow flags", CTL, 8'hc6);
		rchk("count high", 8'hcd, 8'hff);
		wr(CTL, 8'h46);
		tick(2);
		irq_chk("irq up down", 1'b0);
		wr(CTL, 8'h00);
		wr(MD, 8'h00);
		i_crt_pin_source.set_trig(1'b1);
		$display("down count test done");
		wr16(CAP, 16'hfff0);
		wr16(CNT, 16'hfff0);
		b_rx = n_rx;
		b_tx = n_tx;
		b_irq = n_irq;
		run_for(8'h35, 6);
		chk("rx pulses", 8'h02, 8'(n_rx - b_rx));
		chk("tx pulses", 8'h02, 8'(n_tx - b_tx));
		chk("irq in baud", 8'h00, 8'(n_irq - b_irq));
		rchk16("baud count", CNT, 16'hfff4);
		b_rx = n_rx;
		b_tx = n_tx;
		t1_ovf_pulse <= 1'b1;
		tick(1);
		t1_ovf_pulse <= 1'b0;
		tick(3);
		chk("other rx", 8'h01, 8'(n_rx - b_rx));
		chk("other tx", 8'h01, 8'(n_tx - b_tx));
		$display("baud test done");
		end_of_test();
	end
endmodule
